//--- core/ssr_top.sv
// Contract
// - Port runs as clock/frame master or as slave to an external master.
// - Separate transmit and receive buffers, eight entries of sixteen bits.
// - Word length programmable from four to sixteen bits.
// - Loopback routes transmit data to receive path; data pins unused, clock and frame pins still driven in master role.
// - Three framings: four-wire, half-duplex command/response, pulsed frame.
// - System clock divided first by an even prescale of 2 to 254.
// - Then divided by one plus the serial rate field, 1 to 256.
// - Bit clock is system clock over prescale times rate plus one.
// - Each data write pushes one word unless the buffer is full, held until serialised.
// - Both roles serialise transmit words onto the output pin.
// - Slave shifts a word at every transfer started by the master.
// - Slave with empty buffer resends the word written eight writes ago.
// - Fewer than eight writes since clock gate enable: slave sends zero.
// - Transmit-empty can raise the interrupt when enabled.
// - Received words stay buffered until a data read pops them.
// - Serial input bits collect in a register, then load in parallel.
// - Words go out most significant bit first.
// - All interrupt sources are ORed into one request.
// - A source reaches the request only when its mask bit is one.
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "ssr_cfg.svh"

module ssr_top #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        serial_bit_clock_pin_in,
   output logic             serial_bit_clock_pin_out,
   output logic             serial_bit_clock_pin_oe_n,
   input  wire logic        frame_select_pin_in,
   output logic             frame_select_pin_out,
   output logic             frame_select_pin_oe_n,
   input  wire logic        serial_in_pin,
   output logic             serial_out_pin,
   output logic             serial_out_pin_oe_n,
   output logic             irq
);
   localparam int AW = $clog2(DEPTH);
   localparam int PW = AW + 1;
   localparam logic [PW-1:0] FULL = PW'(DEPTH);

   // ----------------------------------------------------------------
   // Shared helpers
   // ----------------------------------------------------------------
   function automatic logic [PW-1:0] f_level(input logic [PW-1:0] wp, input logic [PW-1:0] rp);
      f_level = wp - rp;
   endfunction

   function automatic logic [WIDTH-1:0] f_align(input logic [WIDTH-1:0] w, input logic [3:0] dss);
      f_align = w << (5'(WIDTH - 1) - {1'b0, dss});
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   // Eight-deep buffers
   logic [WIDTH-1:0]     tx_mem [DEPTH];
   logic [WIDTH-1:0]     rx_mem [DEPTH];
   ssr_pkg::ssr_ctrl0_t  ctrl0, next_ctrl0;
   ssr_pkg::ssr_ctrl1_t  ctrl1, next_ctrl1;
   ssr_pkg::ssr_req_t    req, next_req;
   ssr_pkg::ssr_state_t  st, next_st;
   logic [7:0]           presc, next_presc;
   logic [1:0]           imask, next_imask;
   logic                 gate, next_gate;
   logic                 pend, next_pend;
   logic                 next_hready, next_irq;
   logic [31:0]          next_hrdata;
   logic [PW-1:0]        tx_wp, next_tx_wp, tx_rp, next_tx_rp, tx_wcnt, next_tx_wcnt;
   logic [PW-1:0]        rx_wp, next_rx_wp, rx_rp, next_rx_rp;
   logic [6:0]           pre_cnt, next_pre;
   logic [7:0]           rate_cnt, next_rate;
   logic [4:0]           pcnt, next_pcnt, bc, next_bc;
   logic                 half, next_half, sact, next_sact;
   logic [WIDTH-1:0]     tx_sh, next_tx_sh, rx_sh, next_rx_sh, rx_word;
   logic                 next_bclk, next_bclk_oe_n, next_frame, next_frame_oe_n;
   logic                 next_sout, next_sout_oe_n;
   logic                 clk_s1, clk_s2, clk_s3, fr_s1, fr_s2, fr_s3, din_s1, din_s2;
   logic                 tx_push, tx_pop, rx_push, rx_pop, half_tick;
   logic                 tx_empty, tx_full, rx_empty, rx_full, run, master_go, din;
   logic                 clk_rise, clk_fall, fr_rise, fr_fall, is_spi, is_ssf, is_msg;
   logic [WIDTH-1:0]     tx_head, slave_word;
   logic [1:0]           ris;
   logic [4:0]           last;

   assign tx_empty   = (tx_wp == tx_rp);
   assign tx_full    = (f_level(tx_wp, tx_rp) == FULL);
   assign rx_empty   = (rx_wp == rx_rp);
   assign rx_full    = (f_level(rx_wp, rx_rp) == FULL);
   assign tx_head    = tx_mem[tx_rp[AW-1:0]];
   // Slot at the write pointer still holds the write made DEPTH writes ago
   assign slave_word = tx_empty ? ((tx_wcnt == FULL) ? tx_mem[tx_wp[AW-1:0]] : '0) : tx_head;
   assign run        = gate & ctrl1.enable;
   assign master_go  = run & ~ctrl1.slave & ~tx_empty;
   assign is_spi     = (ctrl0.fmt == ssr_pkg::SSR_FMT_SPI);
   assign is_ssf     = (ctrl0.fmt == ssr_pkg::SSR_FMT_SSF);
   assign is_msg     = (ctrl0.fmt == ssr_pkg::SSR_FMT_MSG);
   assign clk_rise   = clk_s2 & ~clk_s3;
   assign clk_fall   = ~clk_s2 & clk_s3;
   assign fr_rise    = fr_s2 & ~fr_s3;
   assign fr_fall    = ~fr_s2 & fr_s3;
   assign ris        = {~rx_empty, tx_empty};
   assign din        = ctrl1.loopback ? tx_sh[WIDTH-1] : din_s2;
   assign last       = is_spi ? {1'b0, ctrl0.dss} :
                       is_ssf ? {1'b0, ctrl0.dss} + 5'd1 : `SSR_RESP_START + {1'b0, ctrl0.dss};

   // ----------------------------------------------------------------
   // Bus slave, registers and buffer pointers
   // ----------------------------------------------------------------
   always_comb begin
      next_req = req;
      next_pend = 1'b0;
      next_hready = 1'b1;
      next_hrdata = hrdata;
      next_ctrl0 = ctrl0;
      next_ctrl1 = ctrl1;
      next_presc = presc;
      next_imask = imask;
      next_gate = gate;
      next_tx_wp = tx_wp;
      next_tx_rp = tx_rp;
      next_tx_wcnt = tx_wcnt;
      next_rx_wp = rx_wp;
      next_rx_rp = rx_rp;
      tx_push = 1'b0;
      rx_pop = 1'b0;
      // One wait state lets every read see the writes before it
      if (hsel && hready && htrans[1]) begin
         next_req = '{addr: haddr[11:0], write: hwrite};
         next_pend = 1'b1;
         next_hready = 1'b0;
      end
      if (pend && req.write) begin
         case (req.addr)
            `SSR_OFF_CTRL0: begin
               next_ctrl0 = ssr_pkg::ssr_ctrl0_t'(hwdata[15:0]);
               next_ctrl0.pad = 2'b00;
               if (hwdata[3:0] < `SSR_DSS_MIN) next_ctrl0.dss = `SSR_DSS_MIN;
               if (hwdata[5:4] == 2'b11) next_ctrl0.fmt = ssr_pkg::SSR_FMT_SPI;
            end
            `SSR_OFF_CTRL1: next_ctrl1 = ssr_pkg::ssr_ctrl1_t'(hwdata[2:0]);
            `SSR_OFF_PRESC: begin
               next_presc = {hwdata[7:1], 1'b0};
               if (next_presc < `SSR_PRESC_MIN) next_presc = `SSR_PRESC_MIN;
            end
            `SSR_OFF_IMASK: next_imask = hwdata[1:0];
            `SSR_OFF_GATE: begin
               next_gate = hwdata[0];
               if (!gate && hwdata[0]) next_tx_wcnt = '0;
            end
            `SSR_OFF_DATA: tx_push = ~tx_full;
            default: ;
         endcase
      end
      if (pend && !req.write) begin
         case (req.addr)
            `SSR_OFF_CTRL0: next_hrdata = {16'h0000, ctrl0};
            `SSR_OFF_CTRL1: next_hrdata = {29'h0, ctrl1};
            `SSR_OFF_PRESC: next_hrdata = {24'h0, presc};
            `SSR_OFF_IMASK: next_hrdata = {30'h0, imask};
            `SSR_OFF_RIS:   next_hrdata = {30'h0, ris};
            `SSR_OFF_GATE:  next_hrdata = {31'h0, gate};
            `SSR_OFF_STAT:  next_hrdata = {27'h0, (st != ssr_pkg::SSR_IDLE) | sact,
                                           rx_full, ~rx_empty, ~tx_full, tx_empty};
            `SSR_OFF_DATA: begin
               next_hrdata = rx_empty ? 32'h0 : 32'(rx_mem[rx_rp[AW-1:0]]);
               rx_pop = ~rx_empty;
            end
            default: next_hrdata = 32'h0;
         endcase
      end
      if (tx_push) next_tx_wp = tx_wp + PW'(1);
      if (tx_push && tx_wcnt != FULL) next_tx_wcnt = next_tx_wcnt + PW'(1);
      if (tx_pop) next_tx_rp = tx_rp + PW'(1);
      // Overrun: a word arriving at a full buffer is dropped
      if (rx_push && !rx_full) next_rx_wp = rx_wp + PW'(1);
      if (rx_pop) next_rx_rp = rx_rp + PW'(1);
      next_irq = |(ris & imask);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req <= '0;
         pend <= 1'b0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0;
         ctrl0 <= ssr_pkg::ssr_ctrl0_t'(`SSR_CTRL0_RST);
         ctrl1 <= '0;
         presc <= `SSR_PRESC_RST;
         imask <= 2'b00;
         gate <= 1'b0;
         tx_wp <= '0;
         tx_rp <= '0;
         tx_wcnt <= '0;
         rx_wp <= '0;
         rx_rp <= '0;
         irq <= 1'b0;
      end else begin
         req <= next_req;
         pend <= next_pend;
         hreadyout <= next_hready;
         hresp <= 1'b0;
         hrdata <= next_hrdata;
         ctrl0 <= next_ctrl0;
         ctrl1 <= next_ctrl1;
         presc <= next_presc;
         imask <= next_imask;
         gate <= next_gate;
         tx_wp <= next_tx_wp;
         tx_rp <= next_tx_rp;
         tx_wcnt <= next_tx_wcnt;
         rx_wp <= next_rx_wp;
         rx_rp <= next_rx_rp;
         irq <= next_irq;
      end
   end

   // Storage has no reset; the pointers and tx_wcnt decide what is valid
   always_ff @(posedge hclk) begin
      if (tx_push) tx_mem[tx_wp[AW-1:0]] <= hwdata[WIDTH-1:0];
      if (rx_push && !rx_full) rx_mem[rx_wp[AW-1:0]] <= rx_word;
   end

   // ----------------------------------------------------------------
   // Serial engine
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_pre = '0;
      next_rate = '0;
      next_pcnt = pcnt;
      next_half = half;
      next_bc = bc;
      next_sact = sact;
      next_tx_sh = tx_sh;
      next_rx_sh = rx_sh;
      next_bclk = serial_bit_clock_pin_out;
      next_frame = frame_select_pin_out;
      half_tick = 1'b0;
      tx_pop = 1'b0;
      rx_push = 1'b0;
      if (st != ssr_pkg::SSR_IDLE) begin
         next_pre = pre_cnt + 7'd1;
         next_rate = rate_cnt;
         if (pre_cnt == presc[7:1] - 7'd1) begin
            next_pre = '0;
            next_rate = rate_cnt + 8'd1;
            if (rate_cnt == ctrl0.rate) begin
               next_rate = '0;
               half_tick = 1'b1;
            end
         end
      end
      unique case (st)
         ssr_pkg::SSR_IDLE: begin
            if (master_go) begin
               next_st = ssr_pkg::SSR_RUN;
               tx_pop = 1'b1;
               next_tx_sh = is_msg ? {tx_head[7:0], {(WIDTH-8){1'b0}}} : f_align(tx_head, ctrl0.dss);
               next_rx_sh = '0;
               next_pcnt = '0;
               next_half = 1'b0;
               next_frame = 1'b0;
            end
         end
         ssr_pkg::SSR_RUN: begin
            if (half_tick && !half) begin
               next_bclk = 1'b1;
               next_half = 1'b1;
               if (is_ssf && pcnt == 5'd0) next_frame = 1'b1;
               if (is_ssf && pcnt == 5'd1) next_frame = 1'b0;
               if (is_ssf && pcnt >= 5'd2) next_tx_sh = tx_sh << 1;
               if (is_spi || (is_msg && pcnt >= `SSR_RESP_START)) next_rx_sh = {rx_sh[WIDTH-2:0], din};
            end else if (half_tick) begin
               next_bclk = 1'b0;
               next_half = 1'b0;
               if (!is_ssf) next_tx_sh = tx_sh << 1;
               if (is_ssf && pcnt != 5'd0) next_rx_sh = {rx_sh[WIDTH-2:0], din};
               next_pcnt = pcnt + 5'd1;
               if (pcnt == last) begin
                  next_st = ssr_pkg::SSR_GAP;
                  rx_push = 1'b1;
                  next_frame = ~is_ssf;
               end
            end
         end
         ssr_pkg::SSR_GAP: begin
            // Full idle period keeps back-to-back words framed apart
            if (half_tick) begin
               next_half = ~half;
               if (half) next_st = ssr_pkg::SSR_IDLE;
            end
         end
      endcase
      if (run && ctrl1.slave) begin
         if ((is_ssf && fr_rise) || (!is_ssf && fr_fall)) begin
            next_sact = 1'b1;
            next_bc = '0;
            next_rx_sh = '0;
            next_tx_sh = f_align(slave_word, ctrl0.dss);
            tx_pop = ~tx_empty;
         end else if (sact && !is_ssf && fr_s2) begin
            next_sact = 1'b0;
         end else if (sact && is_spi) begin
            if (clk_rise) begin
               next_rx_sh = {rx_sh[WIDTH-2:0], din};
               next_bc = bc + 5'd1;
               rx_push = (bc == {1'b0, ctrl0.dss});
               next_sact = ~rx_push;
            end
            if (clk_fall) next_tx_sh = tx_sh << 1;
         end else if (sact && is_ssf) begin
            if (clk_rise && bc >= 5'd2) next_tx_sh = tx_sh << 1;
            if (clk_fall) begin
               if (bc != 5'd0) next_rx_sh = {rx_sh[WIDTH-2:0], din};
               next_bc = bc + 5'd1;
               rx_push = (bc == {1'b0, ctrl0.dss} + 5'd1);
               next_sact = ~rx_push;
            end
         end else if (sact && is_msg) begin
            if (clk_rise) begin
               if (bc < `SSR_CMD_BITS) next_rx_sh = {rx_sh[WIDTH-2:0], din};
               rx_push = (bc == `SSR_CMD_BITS - 5'd1);
               if (bc != 5'd31) next_bc = bc + 5'd1;
            end
            if (clk_fall && bc >= `SSR_RESP_SHIFT) next_tx_sh = tx_sh << 1;
         end
      end
      if (!run) begin
         next_st = ssr_pkg::SSR_IDLE;
         next_sact = 1'b0;
         next_bclk = 1'b0;
         next_frame = ~is_ssf;
      end
      rx_word = next_rx_sh;
      next_bclk_oe_n = ctrl1.slave;
      next_frame_oe_n = ctrl1.slave;
      if (ctrl1.slave) begin
         next_sout_oe_n = ~(next_sact && (!is_msg || next_bc >= `SSR_RESP_START));
      end else begin
         next_sout_oe_n = is_ssf && (next_st != ssr_pkg::SSR_RUN);
      end
      if (ctrl1.loopback) next_sout_oe_n = 1'b1;
      next_sout = ~next_sout_oe_n & next_tx_sh[WIDTH-1];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= ssr_pkg::SSR_IDLE;
         pre_cnt <= '0;
         rate_cnt <= '0;
         pcnt <= '0;
         half <= 1'b0;
         bc <= '0;
         sact <= 1'b0;
         tx_sh <= '0;
         rx_sh <= '0;
         serial_bit_clock_pin_out <= 1'b0;
         serial_bit_clock_pin_oe_n <= 1'b0;
         frame_select_pin_out <= 1'b1;
         frame_select_pin_oe_n <= 1'b0;
         serial_out_pin <= 1'b0;
         serial_out_pin_oe_n <= 1'b0;
         // Clock stages start at the idle low level so no false edge follows reset
         {clk_s1, clk_s2, clk_s3, fr_s1, fr_s2, fr_s3, din_s1, din_s2} <= 8'h1f;
      end else begin
         st <= next_st;
         pre_cnt <= next_pre;
         rate_cnt <= next_rate;
         pcnt <= next_pcnt;
         half <= next_half;
         bc <= next_bc;
         sact <= next_sact;
         tx_sh <= next_tx_sh;
         rx_sh <= next_rx_sh;
         serial_bit_clock_pin_out <= next_bclk;
         serial_bit_clock_pin_oe_n <= next_bclk_oe_n;
         frame_select_pin_out <= next_frame;
         frame_select_pin_oe_n <= next_frame_oe_n;
         serial_out_pin <= next_sout;
         serial_out_pin_oe_n <= next_sout_oe_n;
         // Slave needs the 12x clock margin for these stages
         // Master capture lags two cycles, so it needs a half period of three or more
         {clk_s1, clk_s2, clk_s3} <= {serial_bit_clock_pin_in, clk_s1, clk_s2};
         {fr_s1, fr_s2, fr_s3} <= {frame_select_pin_in, fr_s1, fr_s2};
         {din_s1, din_s2} <= {serial_in_pin, din_s1};
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [15:0] hc;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) hc <= '0;
      else if (st == ssr_pkg::SSR_IDLE || half_tick) hc <= '0;
      else hc <= hc + 16'd1;
   end

   half_period_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (half_tick && $stable(presc) && $stable(ctrl0.rate)) |->
      hc == 16'(presc[7:1]) * (16'(ctrl0.rate) + 16'd1) - 16'd1)
      else $error("Bit clock half period wrong");
   clk_toggle_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (st == ssr_pkg::SSR_RUN && run && half_tick) |=> $changed(serial_bit_clock_pin_out))
      else $error("Bit clock missed a toggle");
   presc_even_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !presc[0] && presc >= `SSR_PRESC_MIN)
      else $error("Prescale odd or below minimum");
   tx_depth_a: assert property (@(posedge hclk) disable iff (!hresetn)
      f_level(tx_wp, tx_rp) <= FULL && f_level(rx_wp, rx_rp) <= FULL)
      else $error("Buffer level beyond depth");
   master_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (st == ssr_pkg::SSR_IDLE && !master_go) |=> st == ssr_pkg::SSR_IDLE)
      else $error("Master started without data");
   msb_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (st == ssr_pkg::SSR_IDLE && master_go && !is_msg) |=>
      tx_sh[WIDTH-1] == $past(tx_head[ctrl0.dss]))
      else $error("First bit is not the msb");
   replay_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (run && ctrl1.slave && is_spi && fr_fall && tx_empty && tx_wcnt != FULL) |=> tx_sh == '0)
      else $error("Slave sent nonzero without history");
   push_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (tx_push && !tx_pop) |=> f_level(tx_wp, tx_rp) == $past(f_level(tx_wp, tx_rp)) + PW'(1))
      else $error("Data write did not queue a word");
   rx_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !rx_pop |=> f_level(rx_wp, rx_rp) >= $past(f_level(rx_wp, rx_rp)))
      else $error("Receive word lost without a read");
   irq_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 irq == $past(|(ris & imask)))
      else $error("Interrupt does not follow masked sources");
   loop_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ctrl1.loopback |=> serial_out_pin_oe_n)
      else $error("Data pin driven in loopback");

endmodule

//--- core/ssr_cfg.svh
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SSR_OFF_CTRL0      12'h000
`define SSR_OFF_CTRL1      12'h004
`define SSR_OFF_DATA       12'h008
`define SSR_OFF_STAT       12'h00c
`define SSR_OFF_PRESC      12'h010
`define SSR_OFF_IMASK      12'h014
`define SSR_OFF_RIS        12'h018
`define SSR_OFF_GATE       12'h01c

// ----------------------------------------------------------------
// Reset values, limits and field positions
// ----------------------------------------------------------------
`define SSR_CTRL0_RST      16'h0007
`define SSR_PRESC_RST      8'h02
`define SSR_PRESC_MIN      8'h02
`define SSR_DSS_MIN        4'h3
`define SSR_IM_TXE_BIT     0
`define SSR_IM_RXNE_BIT    1
`define SSR_CMD_BITS       5'd8
`define SSR_RESP_START     5'd9
`define SSR_RESP_SHIFT     5'd10

`endif

//--- core/ssr_pkg.sv
package ssr_pkg;

   typedef enum logic [1:0] {SSR_FMT_SPI, SSR_FMT_SSF, SSR_FMT_MSG} ssr_fmt_t;

   typedef enum logic [1:0] {SSR_IDLE, SSR_RUN, SSR_GAP} ssr_state_t;

   typedef struct packed {
      logic [7:0] rate;
      logic [1:0] pad;
      ssr_fmt_t   fmt;
      logic [3:0] dss;
   } ssr_ctrl0_t;

   typedef struct packed {
      logic loopback;
      logic slave;
      logic enable;
   } ssr_ctrl1_t;

   typedef struct packed {
      logic [11:0] addr;
      logic        write;
   } ssr_req_t;

endpackage

//--- dv/ssr_peer.sv
`timescale 1ns/1ps
// Four-wire slave: answers a fixed word and keeps the word it was sent
module ssr_peer #(
   parameter logic [7:0] REPLY = 8'ha5
) (
   input  wire logic       sclk,
   input  wire logic       fss,
   input  wire logic       mosi,
   output logic            miso,
   output logic [7:0]      got
);
   logic [7:0] sh = 8'h00;
   always @(negedge fss) sh <= REPLY;
   always @(negedge sclk) if (!fss) sh <= {sh[6:0], 1'b0};
   always @(posedge sclk) if (!fss) got <= {got[6:0], mosi};
   // Released line shows the inverse so a stale sample cannot pass
   assign miso = fss ? ~sh[7] : sh[7];
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps
`include "ssr_cfg.svh"
module testbench;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hrdy, hresp, irq;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rv;
   logic [1:0]  htrans = 0;
   logic sck_o, sck_oe_n, fs_o, fs_oe_n, miso, mosi, mosi_oe_n, sck, fs;
   logic [7:0]  got;
   logic m_sck = 0, m_fs = 1, sck_q = 0;
   int err_total = 0, samples_checked = 0, rises, t0, per;
   always #50 hclk = ~hclk;
   assign sck = sck_oe_n ? m_sck : sck_o;
   assign fs = fs_oe_n ? m_fs : fs_o;
   ssr_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
      .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .serial_bit_clock_pin_in(sck),
      .serial_bit_clock_pin_out(sck_o), .serial_bit_clock_pin_oe_n(sck_oe_n),
      .frame_select_pin_in(fs), .frame_select_pin_out(fs_o),
      .frame_select_pin_oe_n(fs_oe_n), .serial_in_pin(miso), .serial_out_pin(mosi),
      .serial_out_pin_oe_n(mosi_oe_n), .irq(irq));
   ssr_peer u_peer (.sclk(sck), .fss(fs), .mosi(mosi), .miso(miso), .got(got));
   task conclude;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Bounded wait for hready high at a rising edge
   task wt;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hrdy !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_total++;
         conclude();
      end
   endtask
   task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
      hsel <= 1;
      haddr <= {20'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      wt();
      htrans <= 2'b00;
      hwdata <= d;
      wt();
      rv = hrdata;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
      xfer(a, 1'b0, 32'h0);
      chk(nm, rv, e);
      chk("hresp", hresp, 32'h0);
   endtask
   // twelve-cycle bit period keeps the slave margin
   task sframe;
      m_fs <= 0;
      repeat (6) @(posedge hclk);
      repeat (8) begin
         m_sck <= 1;
         repeat (6) @(posedge hclk);
         m_sck <= 0;
         repeat (6) @(posedge hclk);
      end
      m_fs <= 1;
      repeat (6) @(posedge hclk);
   endtask
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      rd(`SSR_OFF_CTRL0, 32'h7, "ctrl0 reset");
      rd(`SSR_OFF_PRESC, 32'h2, "presc reset");
      rd(12'h100, 32'h0, "unmapped");
      xfer(`SSR_OFF_PRESC, 1, 32'hff);
      rd(`SSR_OFF_PRESC, 32'hfe, "presc even");
      xfer(`SSR_OFF_PRESC, 1, 32'h2);
      // Half period of three cycles covers the two-flop input lag
      xfer(`SSR_OFF_CTRL0, 1, 32'h0207);
      xfer(`SSR_OFF_GATE, 1, 32'h1);
      xfer(`SSR_OFF_IMASK, 1, 32'h1);
      @(posedge hclk);
      chk("irq tx empty", irq, 1'b1);
      xfer(`SSR_OFF_IMASK, 1, 32'h0);
      @(posedge hclk);
      chk("irq masked", irq, 1'b0);
      xfer(`SSR_OFF_CTRL1, 1, 32'h1);
      repeat (20) @(posedge hclk);
      chk("idle clock", sck, 1'b0);
      xfer(`SSR_OFF_DATA, 1, 32'h13c);
      rises = 0;
      per = 0;
      t0 = 0;
      for (int i = 0; i < 400 && rises < 8; i++) begin
         @(negedge hclk);
         if (sck && !sck_q) begin
            rises++;
            if (rises == 1) t0 = i;
            if (rises == 2) per = i - t0;
         end
         sck_q = sck;
      end
      if (rises != 8) begin
         err_total++;
         conclude();
      end
      chk("bit period", per, 32'd6);
      repeat (60) @(posedge hclk);
      chk("sent word", got, 8'h3c);
      rd(`SSR_OFF_DATA, 32'ha5, "recv word");
      rd(`SSR_OFF_DATA, 32'h0, "rx empty");
      xfer(`SSR_OFF_CTRL0, 1, 32'h0103);
      xfer(`SSR_OFF_CTRL1, 1, 32'h5);
      xfer(`SSR_OFF_DATA, 1, 32'h1f5);
      repeat (60) @(posedge hclk);
      rd(`SSR_OFF_DATA, 32'h5, "loopback");
      xfer(`SSR_OFF_CTRL0, 1, 32'h0007);
      xfer(`SSR_OFF_CTRL1, 1, 32'h3);
      sframe();
      chk("slave no history", got, 8'h00);
      rd(`SSR_OFF_DATA, 32'ha5, "slave recv");
      for (int k = 0; k < 8; k++) begin
         xfer(`SSR_OFF_DATA, 1, 32'h10 + k);
         sframe();
         chk("slave sent", got, 32'h10 + k);
      end
      sframe();
      chk("slave replay", got, 8'h10);
      conclude();
   end
endmodule
